// ---- rtl/psbt_pkg.sv ----
// psbt_pkg: register map, reset values, field layout, types and timing constants
// assumes one 125 MHz hclk domain and whole-word AHB-Lite access
// Overview of operation
// - separate dead time inside each bridge leg
// - leg one and leg two gaps set separately
// - one load sensitivity shared by both legs
// - zero bridge sensitivity keeps dead times fixed
// - rectifier falls a set delay after primary
// - rectifier delay grows with sensed current
// - zero rectifier sensitivity gives fixed delay
// - minimum pulse in 5.92 ns units enforced
// - short demand gives even count of minimum pulses
// - burst ends on the leg-two-high cycle unless run is cleared
// - shutdown until demand reaches the minimum pulse
// - master drives half-duty sync at oscillator rate
// - slave runs ninety degrees behind the master
// - oscillator runs at twice switching frequency
// - ramp added at limit and peak comparators
`default_nettype none
package psbt_pkg;
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned MINP_UNIT_PS  = 5920;
  localparam int unsigned SENS_SHIFT    = 12;

  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_OSC       = 8'h04;
  localparam logic [7:0] OFF_DEMAND    = 8'h08;
  localparam logic [7:0] OFF_LEG1_GAP  = 8'h0C;
  localparam logic [7:0] OFF_LEG2_GAP  = 8'h10;
  localparam logic [7:0] OFF_RECT_GAP  = 8'h14;
  localparam logic [7:0] OFF_SENS      = 8'h18;
  localparam logic [7:0] OFF_MIN_PULSE = 8'h1C;
  localparam logic [7:0] OFF_SENSE     = 8'h20;
  localparam logic [7:0] OFF_RAMP      = 8'h24;
  localparam logic [7:0] OFF_LIMIT     = 8'h28;
  localparam logic [7:0] OFF_STATUS    = 8'h2C;

  localparam int unsigned CTRL_RUN_BIT   = 0;
  localparam int unsigned CTRL_SLAVE_BIT = 1;
  localparam int unsigned CTRL_PEAK_BIT  = 2;
  localparam int unsigned SENS_RECT_LSB  = 4;
  localparam int unsigned LIMIT_PEAK_LSB = 8;

  localparam logic [15:0] RST_OSC_PERIOD = 16'h0271;
  localparam logic [15:0] RST_DEMAND     = 16'h0064;
  localparam logic [7:0]  RST_GAP        = 8'h08;
  localparam logic [7:0]  RST_MIN_PULSE  = 8'h0D;
  localparam logic [7:0]  RST_LEVEL      = 8'hFF;

  typedef enum logic [1:0] {
    PSBT_RUN   = 2'b00,
    PSBT_BURST = 2'b01,
    PSBT_SHUT  = 2'b10
  } psbt_mode_t;

  typedef struct packed {
    logic        run_enable;
    logic        slave_select;
    logic        peak_mode;
    logic [15:0] osc_period;
    logic [15:0] demand;
    logic [7:0]  leg1_gap_setting;
    logic [7:0]  leg2_gap_setting;
    logic [7:0]  rectifier_gap_setting;
    logic [3:0]  bridge_gap_sensitivity;
    logic [3:0]  rectifier_gap_sensitivity;
    logic [7:0]  minimum_on_pulse;
    logic [7:0]  sense_code;
    logic [7:0]  ramp_slope_setting;
    logic [7:0]  limit_level;
    logic [7:0]  peak_level;
  } psbt_cfg_t;
endpackage
`default_nettype wire

// ---- rtl/psbt_core.sv ----
// psbt_core: phase-shifted bridge timing core with AHB-Lite register slave
// assumes hclk at 125 MHz, gate drivers on the drive outputs, sync pin resolved outside
`default_nettype none
module psbt_core (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // bridge and rectifier drives
  output logic             leg1_high_drive,
  output logic             leg1_low_drive,
  output logic             leg2_high_drive,
  output logic             leg2_low_drive,
  output logic             rectifier_drive_one,
  output logic             rectifier_drive_two,
  // sync pin
  input  wire logic        sync_in,
  output logic             sync_out,
  output logic             sync_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  psbt_pkg::psbt_cfg_t  cfg,      next_cfg;
  psbt_pkg::psbt_mode_t mode,     next_mode;
  logic                 ap_write, next_ap_write;
  logic [7:0]           ap_addr,  next_ap_addr;
  logic [31:0]          rd_data,  next_rd_data;
  logic [15:0]          osc_cnt,  next_osc_cnt;
  logic                 half,     next_half;
  logic [2:0]           sync_sh,  next_sync_sh;
  logic                 sync_lvl, next_sync_lvl;
  logic                 sync_o,   next_sync_o;
  logic                 sync_e,   next_sync_e;
  logic [15:0]          ramp,     next_ramp;
  logic                 cl_trip,  next_cl_trip;
  logic                 pk_trip,  next_pk_trip;
  logic [1:0]           drv_hi, drv_lo, rect;
  logic [1:0]           tgt_hi, prim;
  logic [7:0]           gap_leg [2];
  logic [8:0]           gap_ef;
  logic [19:0]          adj_leg [2];
  logic [19:0]          adj_ef;
  logic [31:0]          minp_num;
  logic [15:0]          minp_cyc, period, per_half, on_time;
  logic [12:0]          cmp_val;
  logic                 take, sync_rise, period_start, demand_ok, pw_on, legs_en;

  // bus slave: zero wait states, address phase registered
  always_comb begin
    logic [31:0] rv;
    rv            = 32'h0000_0000;
    take          = hsel && htrans[1] && hready;
    next_ap_write = take && hwrite && (haddr[31:8] == 24'h00_0000);
    next_ap_addr  = take ? haddr[7:0] : ap_addr;
    unique case (haddr[7:0])
      psbt_pkg::OFF_CTRL:      rv = {29'h0, cfg.peak_mode, cfg.slave_select, cfg.run_enable};
      psbt_pkg::OFF_OSC:       rv = {16'h0000, cfg.osc_period};
      psbt_pkg::OFF_DEMAND:    rv = {16'h0000, cfg.demand};
      psbt_pkg::OFF_LEG1_GAP:  rv = {24'h00_0000, cfg.leg1_gap_setting};
      psbt_pkg::OFF_LEG2_GAP:  rv = {24'h00_0000, cfg.leg2_gap_setting};
      psbt_pkg::OFF_RECT_GAP:  rv = {24'h00_0000, cfg.rectifier_gap_setting};
      psbt_pkg::OFF_SENS:      rv = {24'h00_0000, cfg.rectifier_gap_sensitivity,
                                     cfg.bridge_gap_sensitivity};
      psbt_pkg::OFF_MIN_PULSE: rv = {24'h00_0000, cfg.minimum_on_pulse};
      psbt_pkg::OFF_SENSE:     rv = {24'h00_0000, cfg.sense_code};
      psbt_pkg::OFF_RAMP:      rv = {24'h00_0000, cfg.ramp_slope_setting};
      psbt_pkg::OFF_LIMIT:     rv = {16'h0000, cfg.peak_level, cfg.limit_level};
      psbt_pkg::OFF_STATUS:    rv = {20'h0_0000, rect, drv_lo, drv_hi, pk_trip, cl_trip,
                                     half, 1'b0, mode};
      default:                 rv = 32'h0000_0000;
    endcase
    next_rd_data = (take && !hwrite && haddr[31:8] == 24'h00_0000) ? rv : 32'h0000_0000;
    next_cfg = cfg;
    if (ap_write) begin
      unique case (ap_addr)
        psbt_pkg::OFF_CTRL: begin
          next_cfg.run_enable   = hwdata[psbt_pkg::CTRL_RUN_BIT];
          next_cfg.slave_select = hwdata[psbt_pkg::CTRL_SLAVE_BIT];
          next_cfg.peak_mode    = hwdata[psbt_pkg::CTRL_PEAK_BIT];
        end
        psbt_pkg::OFF_OSC:       next_cfg.osc_period = hwdata[15:0];
        psbt_pkg::OFF_DEMAND:    next_cfg.demand = hwdata[15:0];
        psbt_pkg::OFF_LEG1_GAP:  next_cfg.leg1_gap_setting = hwdata[7:0];
        psbt_pkg::OFF_LEG2_GAP:  next_cfg.leg2_gap_setting = hwdata[7:0];
        psbt_pkg::OFF_RECT_GAP:  next_cfg.rectifier_gap_setting = hwdata[7:0];
        psbt_pkg::OFF_SENS: begin
          next_cfg.bridge_gap_sensitivity    = hwdata[3:0];
          next_cfg.rectifier_gap_sensitivity = hwdata[psbt_pkg::SENS_RECT_LSB +: 4];
        end
        psbt_pkg::OFF_MIN_PULSE: next_cfg.minimum_on_pulse = hwdata[7:0];
        psbt_pkg::OFF_SENSE:     next_cfg.sense_code = hwdata[7:0];
        psbt_pkg::OFF_RAMP:      next_cfg.ramp_slope_setting = hwdata[7:0];
        psbt_pkg::OFF_LIMIT: begin
          next_cfg.limit_level = hwdata[7:0];
          next_cfg.peak_level  = hwdata[psbt_pkg::LIMIT_PEAK_LSB +: 8];
        end
        default: next_cfg = cfg;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg           <= '{run_enable: 1'b0, slave_select: 1'b0, peak_mode: 1'b0,
                         osc_period: psbt_pkg::RST_OSC_PERIOD,
                         demand: psbt_pkg::RST_DEMAND,
                         leg1_gap_setting: psbt_pkg::RST_GAP,
                         leg2_gap_setting: psbt_pkg::RST_GAP,
                         rectifier_gap_setting: psbt_pkg::RST_GAP,
                         bridge_gap_sensitivity: 4'h0, rectifier_gap_sensitivity: 4'h0,
                         minimum_on_pulse: psbt_pkg::RST_MIN_PULSE, sense_code: 8'h00,
                         ramp_slope_setting: 8'h00, limit_level: psbt_pkg::RST_LEVEL,
                         peak_level: psbt_pkg::RST_LEVEL};
      ap_write  <= 1'b0;
      ap_addr   <= 8'h00;
      rd_data   <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      cfg       <= next_cfg;
      ap_write  <= next_ap_write;
      ap_addr   <= next_ap_addr;
      rd_data   <= next_rd_data;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
  assign hrdata = rd_data;

  // settings to cycle counts; sensitivity scales the sensed current code
  always_comb begin
    adj_leg[0] = 20'(cfg.leg1_gap_setting) * 20'(cfg.bridge_gap_sensitivity)
                 * 20'(cfg.sense_code);
    adj_leg[1] = 20'(cfg.leg2_gap_setting) * 20'(cfg.bridge_gap_sensitivity)
                 * 20'(cfg.sense_code);
    adj_ef     = 20'(cfg.rectifier_gap_setting) * 20'(cfg.rectifier_gap_sensitivity)
                 * 20'(cfg.sense_code);
    // bridge gap shrinks with load, never below one cycle
    gap_leg[0] = cfg.leg1_gap_setting - adj_leg[0][psbt_pkg::SENS_SHIFT +: 8];
    gap_leg[1] = cfg.leg2_gap_setting - adj_leg[1][psbt_pkg::SENS_SHIFT +: 8];
    if (gap_leg[0] == 8'h00) gap_leg[0] = 8'h01;
    if (gap_leg[1] == 8'h00) gap_leg[1] = 8'h01;
    // rectifier delay grows with load
    gap_ef = 9'(cfg.rectifier_gap_setting) + 9'(adj_ef[psbt_pkg::SENS_SHIFT +: 8]);
    if (gap_ef == 9'h000) gap_ef = 9'h001;
    minp_num = 32'(cfg.minimum_on_pulse) * psbt_pkg::MINP_UNIT_PS
               + (psbt_pkg::CLK_PERIOD_PS - 1);
    minp_cyc = 16'(minp_num / psbt_pkg::CLK_PERIOD_PS);
    if (minp_cyc == 16'h0000) minp_cyc = 16'h0001;
    period   = (cfg.osc_period < 16'h0002) ? 16'h0002 : cfg.osc_period;
    per_half = period >> 1;
    demand_ok = cfg.demand >= minp_cyc;
  end

  // oscillator, sync filter and sync drive
  always_comb begin
    next_sync_sh  = {sync_sh[1:0], sync_in};
    // stage 0 is read only by stage 1; a level counts once stages 1 and 2 agree
    next_sync_lvl = (sync_sh[1] == sync_sh[2]) ? sync_sh[2] : sync_lvl;
    sync_rise     = next_sync_lvl && !sync_lvl;
    next_half     = half;
    if (osc_cnt >= period - 16'h0001 && !(cfg.slave_select && sync_rise)) begin
      next_osc_cnt = 16'h0000;
      next_half    = !half;
    end else begin
      next_osc_cnt = osc_cnt + 16'h0001;
    end
    if (cfg.slave_select && sync_rise) next_osc_cnt = per_half;
    next_sync_e = !cfg.slave_select;
    next_sync_o = !cfg.slave_select && (sync_o ? next_osc_cnt < per_half : ~|next_osc_cnt);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_cnt  <= 16'h0000;
      half     <= 1'b0;
      sync_sh  <= 3'b000;
      sync_lvl <= 1'b0;
      sync_o   <= 1'b0;
      sync_e   <= 1'b0;
    end else begin
      osc_cnt  <= next_osc_cnt;
      half     <= next_half;
      sync_sh  <= next_sync_sh;
      sync_lvl <= next_sync_lvl;
      sync_o   <= next_sync_o;
      sync_e   <= next_sync_e;
    end
  end
  assign sync_out = sync_o;
  assign sync_oe  = sync_e;

  // operating mode and pulse width; limit comparator may cut below the minimum
  always_comb begin
    period_start = (osc_cnt == 16'h0000) && !half;
    cmp_val      = 13'(cfg.sense_code) + 13'(ramp[15:4]);
    next_ramp    = ramp;
    if (osc_cnt == 16'h0000) next_ramp = 16'h0000;
    else if (17'(ramp) + 17'(cfg.ramp_slope_setting) > 17'h0FFFF) next_ramp = 16'hFFFF;
    else next_ramp = ramp + 16'(cfg.ramp_slope_setting);
    next_cl_trip = (osc_cnt == 16'h0000) ? 1'b0
                 : (cl_trip || cmp_val >= 13'(cfg.limit_level));
    next_pk_trip = (osc_cnt == 16'h0000) ? 1'b0
                 : (pk_trip || (cfg.peak_mode && cmp_val >= 13'(cfg.peak_level)));
    next_mode = mode;
    unique case (mode)
      psbt_pkg::PSBT_RUN:
        if (!cfg.run_enable) next_mode = psbt_pkg::PSBT_SHUT;
        else if (period_start && !demand_ok) next_mode = psbt_pkg::PSBT_BURST;
      psbt_pkg::PSBT_BURST:
        // entered at a period start, so the next one closes a whole pair
        if (!cfg.run_enable) next_mode = psbt_pkg::PSBT_SHUT;
        else if (period_start) next_mode = demand_ok ? psbt_pkg::PSBT_RUN
                                                     : psbt_pkg::PSBT_SHUT;
      psbt_pkg::PSBT_SHUT:
        if (cfg.run_enable && period_start && demand_ok) next_mode = psbt_pkg::PSBT_RUN;
      default: next_mode = psbt_pkg::PSBT_SHUT;
    endcase
    unique case (mode)
      psbt_pkg::PSBT_RUN:   on_time = demand_ok ? cfg.demand : minp_cyc;
      psbt_pkg::PSBT_BURST: on_time = minp_cyc;
      default:              on_time = 16'h0000;
    endcase
    legs_en = (mode != psbt_pkg::PSBT_SHUT);
    if (cfg.peak_mode) pw_on = legs_en && !cl_trip && (osc_cnt < minp_cyc || !pk_trip);
    else pw_on = !cl_trip && (osc_cnt < on_time);
    // half 0 delivers leg1 high with leg2 low, half 1 leg1 low with leg2 high
    tgt_hi[0] = !half;
    tgt_hi[1] = half ? pw_on : !pw_on;
    prim[0]   = drv_hi[0];
    prim[1]   = drv_lo[0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode    <= psbt_pkg::PSBT_SHUT;
      ramp    <= 16'h0000;
      cl_trip <= 1'b0;
      pk_trip <= 1'b0;
    end else begin
      mode    <= next_mode;
      ramp    <= next_ramp;
      cl_trip <= next_cl_trip;
      pk_trip <= next_pk_trip;
    end
  end

  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : g_ch
      logic [7:0] gcnt, next_gcnt, gap_lat, next_gap_lat;
      logic [8:0] rcnt, next_rcnt, ef_lat, next_ef_lat;
      logic [9:0] off_len, next_off_len, plow_len, next_plow_len;
      logic       next_hi, next_lo, next_rect;
      logic       on_any;

      // leg: break first, then make after the gap
      always_comb begin
        on_any       = drv_hi[k] || drv_lo[k];
        next_hi      = drv_hi[k];
        next_lo      = drv_lo[k];
        next_gcnt    = gcnt;
        next_gap_lat = gap_lat;
        if (!legs_en || (drv_hi[k] && !tgt_hi[k]) || (drv_lo[k] && tgt_hi[k])) begin
          next_hi      = 1'b0;
          next_lo      = 1'b0;
          next_gcnt    = gap_leg[k];
          next_gap_lat = gap_leg[k];
        end else if (!on_any) begin
          if (gcnt <= 8'h01) begin
            next_hi = tgt_hi[k];
            next_lo = !tgt_hi[k];
          end else begin
            next_gcnt = gcnt - 8'h01;
          end
        end
        next_off_len = on_any ? 10'h000 : ((off_len == 10'h3FF) ? off_len : off_len + 10'h001);
        // rectifier: rises with its primary, falls gap_ef cycles after it falls
        next_rcnt   = rcnt;
        next_ef_lat = ef_lat;
        next_rect   = rect[k];
        if (prim[k]) begin
          next_rect   = 1'b1;
          next_rcnt   = gap_ef;
          next_ef_lat = gap_ef;
        end else if (rcnt > 9'h001) begin
          next_rcnt = rcnt - 9'h001;
        end else begin
          next_rect = 1'b0;
        end
        next_plow_len = prim[k] ? 10'h000
                      : ((plow_len == 10'h3FF) ? plow_len : plow_len + 10'h001);
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          drv_hi[k] <= 1'b0;
          drv_lo[k] <= 1'b0;
          rect[k]   <= 1'b0;
          gcnt      <= 8'h00;
          gap_lat   <= 8'h01;
          rcnt      <= 9'h000;
          ef_lat    <= 9'h001;
          off_len   <= 10'h3FF;
          plow_len  <= 10'h3FF;
        end else begin
          drv_hi[k] <= next_hi;
          drv_lo[k] <= next_lo;
          rect[k]   <= next_rect;
          gcnt      <= next_gcnt;
          gap_lat   <= next_gap_lat;
          rcnt      <= next_rcnt;
          ef_lat    <= next_ef_lat;
          off_len   <= next_off_len;
          plow_len  <= next_plow_len;
        end
      end

      a_leg_no_overlap: assert property (!(drv_hi[k] && drv_lo[k]))
        else $error("both outputs of one leg high");
      a_leg_gap_held: assert property ($rose(drv_hi[k] || drv_lo[k]) |-> off_len >= 10'(gap_lat))
        else $error("leg turned on before its dead time");
      a_rect_fall_delay: assert property ($fell(rect[k]) |-> plow_len == 10'(ef_lat))
        else $error("rectifier fell at wrong delay after primary");
    end
  endgenerate

  assign leg1_high_drive     = drv_hi[0];
  assign leg1_low_drive      = drv_lo[0];
  assign leg2_high_drive     = drv_hi[1];
  assign leg2_low_drive      = drv_lo[1];
  assign rectifier_drive_one = rect[0];
  assign rectifier_drive_two = rect[1];

  a_bridge_gap_fixed: assert property ((cfg.bridge_gap_sensitivity == 4'h0
      && cfg.leg1_gap_setting != 8'h00) |-> gap_leg[0] == cfg.leg1_gap_setting)
    else $error("bridge gap moved with zero sensitivity");
  a_rect_gap_fixed: assert property ((cfg.rectifier_gap_sensitivity == 4'h0
      && cfg.rectifier_gap_setting != 8'h00) |-> gap_ef == 9'(cfg.rectifier_gap_setting))
    else $error("rectifier gap moved with zero sensitivity");
  a_rect_gap_floor: assert property (gap_ef >= 9'(cfg.rectifier_gap_setting))
    else $error("rectifier gap below its setting");
  a_burst_end_phase: assert property ((mode == psbt_pkg::PSBT_BURST && cfg.run_enable
      ##1 mode != psbt_pkg::PSBT_BURST) |-> $past(half, 2))
    else $error("burst ended outside leg-two-high half");
  a_shut_exit_ok: assert property ((mode == psbt_pkg::PSBT_SHUT
      ##1 mode == psbt_pkg::PSBT_RUN) |-> $past(demand_ok))
    else $error("left shutdown with short demand");
  a_half_at_wrap: assert property ($changed(half) |-> osc_cnt == 16'h0000)
    else $error("switching half changed off the oscillator wrap");
  a_sync_rise_wrap: assert property ($rose(sync_out) |-> osc_cnt == 16'h0000 && sync_oe)
    else $error("master sync rose away from oscillator start");
  a_slave_phase: assert property ((cfg.slave_select && sync_rise) |=> osc_cnt == $past(per_half))
    else $error("slave not realigned half an oscillator cycle");

  c_burst_entry: cover property (mode == psbt_pkg::PSBT_RUN ##1 mode == psbt_pkg::PSBT_BURST);
  c_shut_to_run: cover property (mode == psbt_pkg::PSBT_SHUT ##1 mode == psbt_pkg::PSBT_RUN);
  c_limit_trip:  cover property ($rose(cl_trip));
  c_slave_align: cover property (cfg.slave_select && sync_rise);
endmodule
`default_nettype wire

// ---- verif/psbt_sync_peer.sv ----
// psbt_sync_peer: paired controller acting as sync master on the shared sync pin
// assumes hclk shared with the bench; bench resolves the pin with a pull-down
`default_nettype none
module psbt_sync_peer (
  // clock and control
  input  wire logic        hclk,
  input  wire logic        enable,
  input  wire logic [15:0] period,
  // sync pin drive
  output logic             drive,
  output logic             drive_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt = 16'h0000;
  always @(posedge hclk) begin
    cnt <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
  end
  assign drive    = enable && (cnt < (period >> 1));
  // released pin falls to the pull-down level, never the last value
  assign drive_oe = enable;
endmodule
`default_nettype wire

// ---- verif/psbt_core_tb.sv ----
// psbt_core_tb: self-checking bench for the bridge timing core
// assumes psbt_pkg and psbt_core compiled first, sync pin pulled down
`default_nettype none
module psbt_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout, hresp, l1h, l1l, l2h, l2l, r1, r2, s_out, s_oe, p_drv, p_oe;
  logic        peer_en = 1'b0;
  logic        p1h, p1l, pr1, pr2, ps, ovl;
  logic [1:0]  kind = 2'h0;
  logic [31:0] hrdata, v, fails, check_count;
  logic [31:0] n1, n2, c1, c2, sh, sc, sw, g1, g2, gr1, gr2, gs, gph, gsw;
  wire logic   sync_pin = s_oe ? s_out : (p_oe & p_drv);
  psbt_core u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .leg1_high_drive(l1h),
    .leg1_low_drive(l1l), .leg2_high_drive(l2h), .leg2_low_drive(l2l),
    .rectifier_drive_one(r1), .rectifier_drive_two(r2), .sync_in(sync_pin),
    .sync_out(s_out), .sync_oe(s_oe));
  psbt_sync_peer u_peer (.hclk(hclk), .enable(peer_en), .period(16'h0028),
    .drive(p_drv), .drive_oe(p_oe));
  initial begin
    fails = 32'h0;
    check_count = 32'h0;
    {n1, n2, c1, c2, sh, sc, sw, g1, g2, gr1, gr2, gs, gph, gsw} = '0;
    {p1h, p1l, pr1, pr2, ps, ovl} = '0;
    forever #4 hclk = ~hclk;
  end
  // sample mid-cycle so settled register outputs are seen
  always @(negedge hclk) begin
    if (l1h || l1l) begin if (n1 != 0) g1 = n1; n1 = 0; end else n1 = n1 + 32'h1;
    if (l2h || l2l) begin if (n2 != 0) g2 = n2; n2 = 0; end else n2 = n2 + 32'h1;
    {c1, c2, sc, sw} = {c1 + 32'h1, c2 + 32'h1, sc + 32'h1, sw + 32'h1};
    if (p1h && !l1h) c1 = 0;
    if (p1l && !l1l) c2 = 0;
    if (pr1 && !r1) gr1 = c1;
    if (pr2 && !r2) gr2 = c2;
    if (s_out) sh = sh + 32'h1; else begin if (sh != 0) gs = sh; sh = 0; end
    if (!ps && sync_pin) sc = 0;
    if ((p1h && !l1h) || (p1l && !l1l)) gph = sc;
    if (!p1h && l1h) begin gsw = sw; sw = 0; end
    if (l1h && l2l) kind = 2'h1;
    if (l1l && l2h) kind = 2'h2;
    if ((l1h && l1l) || (l2h && l2l)) ovl = 1'b1;
    {p1h, p1l, pr1, pr2, ps} = {l1h, l1l, r1, r2, sync_pin};
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 32'h1;
    if (got !== exp) begin
      fails = fails + 32'h1;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, a, 2'b10, w};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    check(v, exp);
  endtask
  task automatic chk_mode(input logic [1:0] m);
    xfer(psbt_pkg::OFF_STATUS, 1'b0, 32'h0);
    check({30'h0, v[1:0]}, {30'h0, m});
  endtask
  function automatic logic [31:0] gap(input logic [31:0] s, k, c, input logic up);
    logic [31:0] d;
    d = (s * k * c) >> 12;
    gap = up ? s + d : ((s > d) ? s - d : 32'h0);
    if (gap == 32'h0) gap = 32'h1;
  endfunction
  task automatic t_reset;
    chk_rd(psbt_pkg::OFF_OSC, 32'h271);
    chk_rd(psbt_pkg::OFF_DEMAND, 32'h64);
    chk_rd(psbt_pkg::OFF_MIN_PULSE, 32'hD);
    chk_rd(psbt_pkg::OFF_LEG2_GAP, 32'h8);
    chk_rd(psbt_pkg::OFF_LIMIT, 32'hFFFF);
    chk_rd(8'h30, 32'h0);
    check({31'h0, hresp}, 32'h0);
  endtask
  task automatic t_gaps(input logic [31:0] k, input logic [31:0] rk, input logic [31:0] c);
    wr(psbt_pkg::OFF_OSC, 32'h28);
    wr(psbt_pkg::OFF_DEMAND, 32'h14);
    wr(psbt_pkg::OFF_LEG1_GAP, 32'h6);
    wr(psbt_pkg::OFF_LEG2_GAP, 32'h9);
    wr(psbt_pkg::OFF_RECT_GAP, 32'h5);
    wr(psbt_pkg::OFF_SENS, (rk << 4) | k);
    wr(psbt_pkg::OFF_SENSE, c);
    wr(psbt_pkg::OFF_CTRL, 32'h1);
    repeat (400) @(posedge hclk);
    check(g1, gap(32'h6, k, c, 1'b0));
    check(g2, gap(32'h9, k, c, 1'b0));
    check(gr1, gap(32'h5, rk, c, 1'b1));
    check(gr2, gap(32'h5, rk, c, 1'b1));
    check({31'h0, ovl}, 32'h0);
  endtask
  task automatic t_sync;
    check(gs, 32'h14);
    check(gsw, 32'h50);
    check({31'h0, s_oe}, 32'h1);
  endtask
  task automatic t_burst;
    wr(psbt_pkg::OFF_DEMAND, 32'hA);
    repeat (400) @(posedge hclk);
    chk_mode(2'h0);
    wr(psbt_pkg::OFF_DEMAND, 32'h9);
    repeat (640) @(posedge hclk);
    chk_mode(2'h2);
    check({30'h0, kind}, 32'h2);
    check({26'h0, l1h, l1l, l2h, l2l, r1, r2}, 32'h0);
    wr(psbt_pkg::OFF_DEMAND, 32'hA);
    repeat (400) @(posedge hclk);
    chk_mode(2'h0);
  endtask
  // limit far below the sensed code cuts every power-delivery interval
  task automatic t_limit;
    wr(psbt_pkg::OFF_LIMIT, 32'hFF10);
    repeat (100) @(posedge hclk);
    kind = 2'h0;
    repeat (200) @(posedge hclk);
    check({30'h0, kind}, 32'h0);
    wr(psbt_pkg::OFF_LIMIT, 32'hFFFF);
    repeat (200) @(posedge hclk);
    check({31'h0, kind != 2'h0}, 32'h1);
  endtask
  task automatic t_slave;
    wr(psbt_pkg::OFF_CTRL, 32'h3);
    peer_en <= 1'b1;
    repeat (640) @(posedge hclk);
    check({31'h0, s_oe}, 32'h0);
    check({31'h0, (gph >= 32'h16 && gph <= 32'h1D)}, 32'h1);
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_gaps(32'h0, 32'h0, 32'hC8);
    t_sync;
    t_gaps(32'hF, 32'hF, 32'hC8);
    t_burst;
    t_limit;
    t_slave;
    give_verdict;
  end
  // run needs under 6000 cycles; a hang ends here
  initial begin
    repeat (60000) @(posedge hclk);
    fails = fails + 32'h1;
    give_verdict;
  end
endmodule
`default_nettype wire
